// ===== rtl/wsd_pkg.sv
/*
 * Constants shared by the word-serial command decoder: command encodings,
 * response formats, register offsets, field positions and reset values.
 * Assumes a 32-bit classic Wishbone register bus with byte addressing.
 */
// What this block does
// - Status byte query 0xCFFF returns the status byte as response.
// - Command 0xCF7F returns the servant address area size.
// - Release 0x8E with address gives up control of that servant by clearing its list bit.
// - Release response status is F on success, 7 if servant not listed.
// - Command 0xEEFF enters locked state by clearing the lock status bit.
// - Lower identity command 0xAE sets lines 0 to 6 only, enable in bit 7.
// - Identity command enable bit one turns on the identity line drivers in Slot 0; outside Slot 0 they are turned off.
// - Upper identity command 0xAD sets lines 7 to 12 only; bit 6 ignored.
// - Identity response status is F on success, 7 when not in Slot 0.
// - Trigger command 0xEDFF starts the previously armed operation.
// - Commands with bit 15 zero are user defined, passed to device logic.
// - An execution error answers with a response whose bit 15 is zero.
// - An unimplemented command records an unsupported error state.
// - Protocol support word shows trigger support by a zero flag bit.
package wsd_pkg;
    localparam logic [15:0] CMD_STATUS_BYTE_QUERY = 16'hCFFF;
    localparam logic [15:0] CMD_SERVANT_AREA      = 16'hCF7F;
    localparam logic [15:0] CMD_SET_LOCK          = 16'hEEFF;
    localparam logic [15:0] CMD_TRIGGER           = 16'hEDFF;
    localparam logic [15:0] CMD_READ_PROTOCOL     = 16'hDFFF;
    localparam logic [15:0] CMD_READ_PROT_ERROR   = 16'hCDFF;
    localparam logic [7:0]  CMD_RELEASE_HI        = 8'h8E;
    localparam logic [7:0]  CMD_LOWER_ID_HI       = 8'hAE;
    localparam logic [7:0]  CMD_UPPER_ID_HI       = 8'hAD;
    localparam int          CMD_USER_BIT          = 15;
    localparam logic [3:0]  STAT_OK               = 4'hF;
    localparam logic [3:0]  STAT_FAIL             = 4'h7;
    localparam logic [11:0] RESP_STAT_FILL        = 12'hFFF;
    localparam logic [15:0] ERR_NONE              = 16'hFFFF;
    localparam logic [15:0] ERR_UNSUPPORTED       = 16'hFFFD;
    localparam int          TRIG_SUPPORT_BIT      = 8;
    localparam logic [15:0] PROTOCOL_WORD         = 16'hFEFF;
    localparam int          ID_LINES              = 13;
    localparam int          ID_LOWER_W            = 7;
    localparam int          ID_UPPER_W            = 6;
    localparam int          ID_ENABLE_BIT         = 7;
    localparam int          LOCK_BIT              = 0;
    // Byte offsets on the register bus
    localparam logic [7:0]  OFF_COMMAND           = 8'h00;
    localparam logic [7:0]  OFF_DATA_LOW          = 8'h04;
    localparam logic [7:0]  OFF_STATUS            = 8'h08;
    localparam logic [7:0]  OFF_CONFIG            = 8'h0C;
    localparam logic [7:0]  OFF_IRQ_STATUS        = 8'h10;
    localparam logic [7:0]  OFF_IRQ_MASK          = 8'h14;
    localparam logic [7:0]  OFF_USER_CMD          = 8'h18;
    localparam logic [7:0]  OFF_IDENTITY          = 8'h1C;
    localparam int          SERVANTS              = 256;
    // Interrupt bits
    localparam int          IRQ_RESP              = 0;
    localparam int          IRQ_TRIGGER           = 1;
    localparam int          IRQ_USER              = 2;
    localparam int          IRQ_ERROR             = 3;
    localparam int          IRQ_W                 = 4;
    localparam logic [15:0] RST_STATUS_BYTE       = 16'hFFFF;
    localparam logic [15:0] RST_AREA_SIZE         = 16'hFFFF;
endpackage : wsd_pkg

// ===== rtl/wsd_list_if.sv
/*
 * Carrier between the decoder and its servant-list memory.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/100ps
interface wsd_list_if;
    logic       we;
    logic [7:0] waddr;
    logic       wdata;
    logic [7:0] raddr;
    logic       rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr,
                  output rdata);
endinterface : wsd_list_if

// ===== rtl/wsd_servant_list.sv
/*
 * One bit per logical address: set while this commander controls it.
 * Read data come out of a register one cycle after the address.
 */
`timescale 1ns/100ps
module wsd_servant_list
(
    // Clock and reset
    input  wire logic   mclk,
    input  wire logic   reset_n,
    // Access port
    wsd_list_if.mem     lst
);
    import wsd_pkg::*;
    typedef struct packed
    {
        logic [SERVANTS-1:0] bits;
        logic                rd;
    } wsd_list_s;
    wsd_list_s st_q;
    wsd_list_s st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.rd = st_q.bits[lst.raddr];
        if (lst.we)
        begin
            st_d.bits[lst.waddr] = lst.wdata;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign lst.rdata = st_q.rd;
endmodule : wsd_servant_list

// ===== rtl/wsd_decoder.sv
/*
 * Word-serial command decoder with a Wishbone register slave.
 * Software writes a command word, the block answers in Data Low.
 * Assumes the identity line pins are resolved outside from the enables.
 */
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module wsd_decoder
(
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    // Wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    // Slot position
    input  wire logic                        in_slot0,
    // Module identity lines
    input  wire logic [wsd_pkg::ID_LINES-1:0] module_identity_lines_i,
    output logic [wsd_pkg::ID_LINES-1:0]     module_identity_lines_o,
    output logic                             module_identity_lines_oe_n,
    // Device side events
    output logic                             trigger_pulse,
    output logic                             user_cmd_pulse,
    output logic                             irq
);
    import wsd_pkg::*;

    typedef enum logic [1:0]
    {
        WSD_IDLE = 2'b00,
        WSD_DEC  = 2'b01,
        WSD_REL  = 2'b10
    } wsd_state_e;

    typedef struct packed
    {
        wsd_state_e          state;
        logic [15:0]         cmd;
        logic [15:0]         data_low;
        logic                resp_valid;
        logic [15:0]         err;
        logic [15:0]         status_byte;
        logic [15:0]         area_size;
        logic                locked_n;
        logic [ID_LINES-1:0] id_out;
        logic                id_oe_n;
        logic [IRQ_W-1:0]    irq_stat;
        logic [IRQ_W-1:0]    irq_mask;
        logic [15:0]         user_cmd;
        logic [31:0]         dat;
        logic                ack;
        logic                trig;
        logic                user;
        logic                irq;
    } wsd_dec_s;

    wsd_dec_s   st_q;
    wsd_dec_s   st_d;
    wsd_list_if lst ();

    wsd_servant_list u_list
    (
        .mclk    (mclk),
        .reset_n (reset_n),
        .lst     (lst.mem)
    );

    logic           req;
    logic           wr;
    logic [IRQ_W-1:0] ev;
    logic [31:0]    rd;

    assign req = wb_cyc_i && wb_stb_i && !st_q.ack;
    assign wr  = req && wb_we_i;

    // Status nibble on top, so a failure answer has bit 15 clear
    function automatic logic [15:0] stat_resp(input logic ok);
        stat_resp = {ok ? STAT_OK : STAT_FAIL, RESP_STAT_FILL};
    endfunction : stat_resp

    always_comb
    begin
        st_d          = st_q;
        ev            = '0;
        rd            = '0;
        st_d.trig     = 1'b0;
        st_d.user     = 1'b0;
        lst.we        = 1'b0;
        lst.waddr     = st_q.cmd[7:0];
        lst.wdata     = 1'b0;
        lst.raddr     = st_q.cmd[7:0];
        unique case (st_q.state)
            WSD_IDLE:
            begin
                if (wr && wb_adr_i == OFF_COMMAND && wb_sel_i[1:0] == 2'b11)
                begin
                    st_d.cmd   = wb_dat_i[15:0];
                    st_d.state = WSD_DEC;
                end
            end
            WSD_DEC:
            begin
                st_d.state      = WSD_IDLE;
                st_d.resp_valid = 1'b1;
                ev[IRQ_RESP]    = 1'b1;
                // Whole-word compare, except user commands (bit 15 only) and release and identity commands (upper byte only)
                if (!st_q.cmd[CMD_USER_BIT])
                begin
                    st_d.user_cmd   = st_q.cmd;
                    st_d.user       = 1'b1;
                    st_d.resp_valid = 1'b0;
                    ev[IRQ_RESP]    = 1'b0;
                    ev[IRQ_USER]    = 1'b1;
                end
                else if (st_q.cmd == CMD_STATUS_BYTE_QUERY)
                    st_d.data_low = st_q.status_byte;
                else if (st_q.cmd == CMD_SERVANT_AREA)
                    st_d.data_low = st_q.area_size;
                else if (st_q.cmd == CMD_SET_LOCK)
                begin
                    st_d.locked_n   = 1'b0;
                    st_d.resp_valid = 1'b0;
                    ev[IRQ_RESP]    = 1'b0;
                end
                else if (st_q.cmd == CMD_TRIGGER)
                begin
                    st_d.trig       = 1'b1;
                    st_d.resp_valid = 1'b0;
                    ev[IRQ_RESP]    = 1'b0;
                    ev[IRQ_TRIGGER] = 1'b1;
                end
                else if (st_q.cmd == CMD_READ_PROTOCOL)
                    st_d.data_low = PROTOCOL_WORD;
                else if (st_q.cmd == CMD_READ_PROT_ERROR)
                begin
                    st_d.data_low = st_q.err;
                    st_d.err      = ERR_NONE;
                end
                else if (st_q.cmd[15:8] == CMD_RELEASE_HI)
                begin
                    // List memory answers one cycle later
                    st_d.state      = WSD_REL;
                    st_d.resp_valid = 1'b0;
                    ev[IRQ_RESP]    = 1'b0;
                end
                else if (st_q.cmd[15:8] == CMD_LOWER_ID_HI ||
                         st_q.cmd[15:8] == CMD_UPPER_ID_HI)
                begin
                    if (in_slot0)
                    begin
                        if (st_q.cmd[15:8] == CMD_LOWER_ID_HI)
                            st_d.id_out[ID_LOWER_W-1:0] =
                                st_q.cmd[ID_LOWER_W-1:0];
                        else
                            st_d.id_out[ID_LINES-1:ID_LOWER_W] =
                                st_q.cmd[ID_UPPER_W-1:0];
                        if (st_q.cmd[ID_ENABLE_BIT])
                            st_d.id_oe_n = 1'b0;
                    end
                    else
                    begin
                        st_d.id_oe_n = 1'b1;
                    end
                    st_d.data_low = stat_resp(in_slot0);
                end
                else
                begin
                    st_d.err        = ERR_UNSUPPORTED;
                    st_d.resp_valid = 1'b0;
                    ev[IRQ_RESP]    = 1'b0;
                    ev[IRQ_ERROR]   = 1'b1;
                end
            end
            WSD_REL:
            begin
                st_d.state      = WSD_IDLE;
                lst.we          = lst.rdata;
                st_d.data_low   = stat_resp(lst.rdata);
                st_d.resp_valid = 1'b1;
                ev[IRQ_RESP]    = 1'b1;
            end
        endcase

        // Register bus: one-cycle ack, unmapped reads give zero
        st_d.ack = req;
        if (req)
        begin
            unique case (wb_adr_i)
                OFF_DATA_LOW:   rd = {16'h0000, st_q.data_low};
                OFF_STATUS:     rd = {27'h0, st_q.id_oe_n,
                                      st_q.state != WSD_IDLE,
                                      st_q.resp_valid, 1'b0, st_q.locked_n};
                OFF_IRQ_STATUS: rd = {28'h0, st_q.irq_stat};
                OFF_IRQ_MASK:   rd = {28'h0, st_q.irq_mask};
                OFF_USER_CMD:   rd = {16'h0000, st_q.user_cmd};
                OFF_IDENTITY:   rd = {19'h0, module_identity_lines_i};
                OFF_CONFIG:     rd = {st_q.area_size, st_q.status_byte};
                default:        rd = '0;
            endcase
            // A fresh response outlives a read in the same cycle
            if (!wb_we_i && wb_adr_i == OFF_DATA_LOW && !ev[IRQ_RESP])
                st_d.resp_valid = 1'b0;
        end
        st_d.dat = rd;
        if (wr && wb_adr_i == OFF_CONFIG)
        begin
            if (wb_sel_i[0]) st_d.status_byte[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) st_d.status_byte[15:8] = wb_dat_i[15:8];
            if (wb_sel_i[2]) st_d.area_size[7:0]    = wb_dat_i[23:16];
            if (wb_sel_i[3]) st_d.area_size[15:8]   = wb_dat_i[31:24];
        end
        // A lock command in the same cycle wins over the unlock write
        if (wr && wb_adr_i == OFF_STATUS && wb_sel_i[0] &&
            wb_dat_i[LOCK_BIT] &&
            !(st_q.state == WSD_DEC && st_q.cmd == CMD_SET_LOCK))
            st_d.locked_n = 1'b1;
        if (wr && wb_adr_i == OFF_IRQ_MASK && wb_sel_i[0])
            st_d.irq_mask = wb_dat_i[IRQ_W-1:0];
        // Servant list is loaded through the identity register write
        if (wr && wb_adr_i == OFF_IDENTITY && st_q.state == WSD_IDLE)
        begin
            lst.we    = 1'b1;
            lst.waddr = wb_dat_i[7:0];
            lst.wdata = wb_dat_i[8];
        end
        // A new event wins over a simultaneous write-one clear
        if (wr && wb_adr_i == OFF_IRQ_STATUS && wb_sel_i[0])
            st_d.irq_stat = st_q.irq_stat & ~wb_dat_i[IRQ_W-1:0];
        st_d.irq_stat = st_d.irq_stat | ev;
        st_d.irq      = |(st_d.irq_stat & st_d.irq_mask);
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q             <= '0;
            st_q.state       <= WSD_IDLE;
            st_q.err         <= ERR_NONE;
            st_q.status_byte <= RST_STATUS_BYTE;
            st_q.area_size   <= RST_AREA_SIZE;
            st_q.locked_n    <= 1'b1;
            st_q.id_oe_n     <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign wb_dat_o                   = st_q.dat;
    assign wb_ack_o                   = st_q.ack;
    assign module_identity_lines_o    = st_q.id_out;
    assign module_identity_lines_oe_n = st_q.id_oe_n;
    assign trigger_pulse              = st_q.trig;
    assign user_cmd_pulse             = st_q.user;
    assign irq                        = st_q.irq;

    property p_status_query;
        @(posedge mclk) disable iff (!reset_n)
        (st_q.state == WSD_DEC && st_q.cmd == CMD_STATUS_BYTE_QUERY)
        |=> st_q.data_low == $past(st_q.status_byte) && st_q.resp_valid;
    endproperty
    a_status_query: assert property (p_status_query)
        else $error("status byte not returned");

    property p_area;
        @(posedge mclk) disable iff (!reset_n)
        (st_q.state == WSD_DEC && st_q.cmd == CMD_SERVANT_AREA)
        |=> st_q.data_low == $past(st_q.area_size);
    endproperty
    a_area: assert property (p_area)
        else $error("area size not returned");

    property p_release;
        @(posedge mclk) disable iff (!reset_n)
        (st_q.state == WSD_DEC && st_q.cmd[15:8] == CMD_RELEASE_HI)
        |=> st_q.state == WSD_REL ##1
            (st_q.data_low[15:12] == STAT_OK ||
             st_q.data_low[15:12] == STAT_FAIL) && st_q.resp_valid;
    endproperty
    a_release: assert property (p_release)
        else $error("release status missing");

    property p_lock;
        @(posedge mclk) disable iff (!reset_n)
        (st_q.state == WSD_DEC && st_q.cmd == CMD_SET_LOCK)
        |=> !st_q.locked_n;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock bit not cleared");

    property p_id_slot;
        @(posedge mclk) disable iff (!reset_n)
        (st_q.state == WSD_DEC && !in_slot0 &&
         (st_q.cmd[15:8] == CMD_LOWER_ID_HI ||
          st_q.cmd[15:8] == CMD_UPPER_ID_HI))
        |=> st_q.id_oe_n && st_q.data_low[15:12] == STAT_FAIL
            && $stable(st_q.id_out);
    endproperty
    a_id_slot: assert property (p_id_slot)
        else $error("identity lines touched outside slot 0");

    property p_id_lower;
        @(posedge mclk) disable iff (!reset_n)
        (st_q.state == WSD_DEC && in_slot0 &&
         st_q.cmd[15:8] == CMD_LOWER_ID_HI)
        |=> st_q.id_out[6:0] == $past(st_q.cmd[6:0]) &&
            st_q.id_out[12:7] == $past(st_q.id_out[12:7]) &&
            st_q.data_low[15:12] == STAT_OK;
    endproperty
    a_id_lower: assert property (p_id_lower)
        else $error("lower identity update wrong");

    property p_id_enable;
        @(posedge mclk) disable iff (!reset_n)
        (st_q.state == WSD_DEC && in_slot0 && st_q.cmd[7] &&
         st_q.cmd[15:8] == CMD_UPPER_ID_HI)
        |=> !module_identity_lines_oe_n &&
            st_q.id_out[12:7] == $past(st_q.cmd[5:0]);
    endproperty
    a_id_enable: assert property (p_id_enable)
        else $error("identity drivers not enabled");

    property p_trigger;
        @(posedge mclk) disable iff (!reset_n)
        (st_q.state == WSD_DEC && st_q.cmd == CMD_TRIGGER)
        |=> trigger_pulse ##1 !trigger_pulse;
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("trigger pulse wrong");

    property p_unsupported;
        @(posedge mclk) disable iff (!reset_n)
        (st_q.state == WSD_DEC && st_q.cmd == 16'hFFFF)
        |=> st_q.err == ERR_UNSUPPORTED && st_q.irq_stat[IRQ_ERROR];
    endproperty
    a_unsupported: assert property (p_unsupported)
        else $error("unsupported command not recorded");
endmodule : wsd_decoder

// ===== tb/wsd_id_bus.sv
/*
 * Backplane model of the module identity lines: pulled up, driven only
 * while the device's enable is low.
 * Assumes the decoder is the only driver on these lines.
 */
`timescale 1ns/100ps
module wsd_id_bus
    import wsd_pkg::*;
(
    // From the driving device
    input  wire logic [wsd_pkg::ID_LINES-1:0] drv,
    input  wire logic                         oe_n,
    // Resolved line levels
    output logic [wsd_pkg::ID_LINES-1:0]      lines
);
    // Pull-ups win when nobody drives, so a stale value never reads back
    assign lines = oe_n ? 13'h1FFF : drv;
endmodule : wsd_id_bus

// ===== tb/word_serial_command_decoder_tb_top.sv
/*
 * Self-checking bench for the command decoder: Wishbone tasks, random and
 * corner commands, interrupt and identity line checks.
 * Assumes the identity line model sits on the decoder's pins.
 */
`timescale 1ns/100ps
module word_serial_command_decoder_tb_top;
    import wsd_pkg::*;
    logic                mclk = 1'b0;
    logic                reset_n = 1'b0;
    logic                cyc = 1'b0;
    logic                stb = 1'b0;
    logic                we = 1'b0;
    logic [7:0]          adr = 8'h00;
    logic [3:0]          sel = 4'hF;
    logic [3:0]          bsel = 4'hF;
    logic [31:0]         wdat = 32'h0;
    logic [31:0]         rdat;
    logic                ack;
    logic                slot0 = 1'b0;
    logic [ID_LINES-1:0] lin;
    logic [ID_LINES-1:0] lout;
    logic [ID_LINES-1:0] exp_l;
    logic                oe_n;
    logic                trg;
    logic                usr;
    logic                irq;
    logic [15:0]         rnd = 16'hE64B;
    logic [15:0]         u;
    logic [31:0]         r;
    int                  n_errors = 0;
    int                  check_count = 0;
    int                  trg_n = 0;
    int                  usr_n = 0;

    always #2 mclk = ~mclk;

    always @(posedge mclk)
    begin
        if (trg === 1'b1) trg_n <= trg_n + 1;
        if (usr === 1'b1) usr_n <= usr_n + 1;
    end

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    function automatic logic [15:0] stat_w(input logic ok);
        return {ok ? STAT_OK : STAT_FAIL, RESP_STAT_FILL};
    endfunction : stat_w

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic print_verdict();
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // Entered just after a rising edge; holds the request until ack
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= bsel;
        wdat <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic cmd(input logic [15:0] c);
        bus(1'b1, OFF_COMMAND, {16'h0000, c});
        repeat (4) @(posedge mclk);
        bus(1'b0, OFF_DATA_LOW, 32'h0);
    endtask : cmd

    initial
    begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        chk({30'h0, ack, oe_n}, 32'h1);
        @(posedge mclk);
        bus(1'b0, OFF_CONFIG, 32'h0);
        chk(r, 32'hFFFFFFFF);
        bus(1'b0, 8'h20, 32'h0);
        chk(r, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            rnd = nxt(rnd);
            bus(1'b1, OFF_CONFIG, {nxt(rnd), rnd});
            cmd(CMD_STATUS_BYTE_QUERY);
            chk(r[15:0], rnd);
            cmd(CMD_SERVANT_AREA);
            chk(r[15:0], nxt(rnd));
            bus(1'b1, OFF_IDENTITY, {23'h0, 1'b1, rnd[7:0]});
            cmd({CMD_RELEASE_HI, rnd[7:0]});
            chk(r[15:0], stat_w(1'b1));
            cmd({CMD_RELEASE_HI, rnd[7:0]});
            chk(r[15:0], stat_w(1'b0));
            u = {1'b0, rnd[14:0]};
            cmd(u);
            bus(1'b0, OFF_USER_CMD, 32'h0);
            chk(r[15:0], u);
        end
        chk(usr_n, 6);
        // Outside Slot 0 the lines must stay released
        cmd({CMD_LOWER_ID_HI, 8'hD5});
        chk(r[15:0], stat_w(1'b0));
        bus(1'b0, OFF_IDENTITY, 32'h0);
        chk({r[12:0], oe_n}, {13'h1FFF, 1'b1});
        slot0 <= 1'b1;
        exp_l = '0;
        for (int i = 0; i < 6; i++)
        begin
            rnd = nxt(rnd);
            cmd({CMD_LOWER_ID_HI, 1'b1, rnd[6:0]});
            chk(r[15:0], stat_w(1'b1));
            exp_l[6:0] = rnd[6:0];
            chk({lout, oe_n}, {exp_l, 1'b0});
            cmd({CMD_UPPER_ID_HI, 1'b1, rnd[15:9]});
            chk(r[15:0], stat_w(1'b1));
            exp_l[12:7] = rnd[14:9];
            bus(1'b0, OFF_IDENTITY, 32'h0);
            chk(r[12:0], exp_l);
        end
        // Command writes without the low byte lanes are refused
        bsel = 4'hC;
        cmd(CMD_TRIGGER);
        chk(trg_n, 0);
        bsel = 4'hF;
        cmd(CMD_TRIGGER);
        chk(trg_n, 1);
        cmd(CMD_READ_PROTOCOL);
        chk(r[TRIG_SUPPORT_BIT], 1'b0);
        cmd(16'hFFFF);
        cmd(CMD_READ_PROT_ERROR);
        chk(r[15:0], ERR_UNSUPPORTED);
        cmd(CMD_READ_PROT_ERROR);
        chk(r[15:0], ERR_NONE);
        bus(1'b1, OFF_STATUS, 32'h1);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(r[LOCK_BIT], 1'b1);
        cmd(CMD_SET_LOCK);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(r[LOCK_BIT], 1'b0);
        // Response, trigger, user and error events have all been raised
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk(r[IRQ_W-1:0], 4'hF);
        bus(1'b1, OFF_IRQ_MASK, 32'h0);
        bus(1'b1, OFF_IRQ_STATUS, 32'hF);
        cmd(CMD_STATUS_BYTE_QUERY);
        @(posedge mclk);
        chk(irq, 1'b0);
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk(r[IRQ_RESP], 1'b1);
        bus(1'b1, OFF_IRQ_MASK, 32'h1);
        @(posedge mclk);
        chk(irq, 1'b1);
        bus(1'b1, OFF_IRQ_STATUS, 32'h1);
        @(posedge mclk);
        chk(irq, 1'b0);
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end

    wsd_decoder wsd_decoder_inst (
        .mclk                       (mclk),
        .reset_n                    (reset_n),
        .wb_cyc_i                   (cyc),
        .wb_stb_i                   (stb),
        .wb_we_i                    (we),
        .wb_adr_i                   (adr),
        .wb_sel_i                   (sel),
        .wb_dat_i                   (wdat),
        .wb_dat_o                   (rdat),
        .wb_ack_o                   (ack),
        .in_slot0                   (slot0),
        .module_identity_lines_i    (lin),
        .module_identity_lines_o    (lout),
        .module_identity_lines_oe_n (oe_n),
        .trigger_pulse              (trg),
        .user_cmd_pulse             (usr),
        .irq                        (irq)
    );

    wsd_id_bus wsd_id_bus_inst (
        .drv   (lout),
        .oe_n  (oe_n),
        .lines (lin)
    );
endmodule : word_serial_command_decoder_tb_top
